// File: core/igdm_monitor.sv
`timescale 1ns/1ps
module igdm_monitor #(
  parameter int unsigned RXB_DEAD_CYC  = igdm_pkg::RXB_DEAD_CYC,
  parameter int unsigned MAIN_DEAD_CYC = igdm_pkg::MAIN_DEAD_CYC,
  parameter int unsigned WARN_CYC      = igdm_pkg::WARN_CYC,
  parameter int unsigned RESTART_CYC   = igdm_pkg::RESTART_CYC,
  parameter int unsigned LIVE_CYC      = igdm_pkg::LIVE_CYC,
  parameter int unsigned ARM_CYC       = igdm_pkg::ARM_CYC
) (
  input  wire logic                 CLK,
  input  wire logic                 RST,
  input  wire logic                 CE,
  input  wire igdm_pkg::igdm_sense_t SENSE,
  input  wire logic                 ENGINE_START,
  input  wire logic                 SPEED_HALF_MAX,
  input  wire logic                 PRG_START,
  input  wire logic                 PRG_WRITE,
  input  wire logic                 PRG_DONE,
  input  wire logic                 NEW_LO_EN,
  input  wire logic [7:0]           NEW_LO,
  input  wire logic                 NEW_HI_EN,
  input  wire logic [7:0]           NEW_HI,
  input  wire logic [1:0]           NEW_LEVEL,
  output logic                      IGN_ENABLE,
  output logic                      SHUTDOWN,
  output logic                      MISFIRE,
  output logic                      RESTART_BLOCK,
  output igdm_pkg::igdm_prg_t       PRG_PHASE,
  output igdm_pkg::igdm_disp_t      DISPLAY,
  output logic [1:0]                LOSS_SENSITIVITY_LEVEL
);

  // Refuse counts too short for the qualification logic
  if (RXB_DEAD_CYC < 2 || MAIN_DEAD_CYC < 2 || WARN_CYC < 2 || RESTART_CYC < 2 ||
      LIVE_CYC < 2 || ARM_CYC < 2) begin : g_bad_count
    $error("igdm_monitor: counts must be at least 2");
  end

  // Saturating counter step
  function automatic logic [31:0] step(input logic [31:0] c, input logic cond, input int unsigned lim);
    step = !cond ? 32'h0 : ((c >= lim) ? c : c + 32'h1);
  endfunction

  // Glitch filter length per level
  function automatic logic [7:0] glitch_len(input logic [1:0] lvl);
    unique case (lvl)
      2'h2:    glitch_len = igdm_pkg::GLITCH_LVL2;
      2'h3:    glitch_len = igdm_pkg::GLITCH_LVL3;
      default: glitch_len = igdm_pkg::GLITCH_LVL1;
    endcase
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [31:0]          rxbd_ff, mand_ff, rxbw_ff, manw_ff, arm_ff, blk_ff, live_ff;
  logic [31:0]          nxt_rxbd, nxt_mand, nxt_rxbw, nxt_manw, nxt_arm, nxt_blk, nxt_live;
  logic [7:0]           bad_ff, nxt_bad;
  logic [7:0]           lo_ff, hi_ff, nxt_lo, nxt_hi;
  logic                 lo_en_ff, hi_en_ff, nxt_lo_en, nxt_hi_en;
  logic [1:0]           lvl_ff, nxt_lvl;
  igdm_pkg::igdm_code_t code_ff, nxt_code;
  logic                 shut_ff, nxt_shut, warn_ff, nxt_warn, run_ff, nxt_run;
  igdm_pkg::igdm_prg_t  prg_ff, nxt_prg;
  logic                 armed, rx_bad, out_range, mon_on, start_ok;

  // ****************************************
  // Monitoring
  // ****************************************
  assign armed     = (arm_ff >= ARM_CYC);
  assign mon_on    = lo_en_ff && hi_en_ff;
  assign out_range = mon_on && SENSE.rx_present &&
                     (SENSE.rx_value > hi_ff || SENSE.rx_value < lo_ff);
  assign rx_bad    = !SENSE.rx_present || out_range;
  assign start_ok  = ENGINE_START && (blk_ff == 32'h0) && (prg_ff == igdm_pkg::IGDM_PRG_IDLE);

  // Fault qualification and latching
  always_comb begin
    nxt_rxbd = step(rxbd_ff, SENSE.rxb_below_dead, RXB_DEAD_CYC);
    nxt_mand = step(mand_ff, SENSE.main_below_dead, MAIN_DEAD_CYC);
    nxt_rxbw = step(rxbw_ff, SENSE.rxb_below_warn, WARN_CYC);
    nxt_manw = step(manw_ff, SENSE.main_below_warn, WARN_CYC);
    nxt_arm  = armed ? arm_ff : arm_ff + 32'h1;
    nxt_bad  = bad_ff;
    if (SENSE.rx_sample) begin
      nxt_bad = (rx_bad && armed) ? ((bad_ff == 8'hFF) ? bad_ff : bad_ff + 8'h1) : 8'h0;
    end
    nxt_code = code_ff;
    nxt_shut = shut_ff;
    nxt_warn = warn_ff;
    nxt_run  = run_ff;
    nxt_blk  = (blk_ff != 32'h0) ? blk_ff - 32'h1 : 32'h0;
    if (start_ok) begin
      nxt_code = igdm_pkg::IGDM_CODE_NONE;
      nxt_shut = 1'b0;
      nxt_warn = 1'b0;
      nxt_run  = 1'b1;
    end else if (run_ff) begin
      if (rxbd_ff >= RXB_DEAD_CYC) begin
        nxt_code = igdm_pkg::IGDM_CODE_RXB_DEAD;
        nxt_shut = 1'b1;
      end else if (mand_ff >= MAIN_DEAD_CYC) begin
        nxt_code = igdm_pkg::IGDM_CODE_MAIN_DEAD;
        nxt_shut = 1'b1;
      end else if (bad_ff >= glitch_len(lvl_ff)) begin
        nxt_code = SENSE.rx_present ? igdm_pkg::IGDM_CODE_RANGE_KILL
                                    : igdm_pkg::IGDM_CODE_RX_MISSING;
        nxt_shut = 1'b1;
      end else if (!warn_ff && rxbw_ff >= WARN_CYC) begin
        nxt_code = igdm_pkg::IGDM_CODE_RXB_WARN;
        nxt_warn = 1'b1;
      end else if (!warn_ff && manw_ff >= WARN_CYC) begin
        nxt_code = igdm_pkg::IGDM_CODE_MAIN_WARN;
        nxt_warn = 1'b1;
      end
      if (nxt_shut) begin
        nxt_run = 1'b0;
        nxt_blk = RESTART_CYC;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rxbd_ff <= 32'h0;
      mand_ff <= 32'h0;
      rxbw_ff <= 32'h0;
      manw_ff <= 32'h0;
      arm_ff  <= 32'h0;
      bad_ff  <= 8'h0;
      blk_ff  <= 32'h0;
      code_ff <= igdm_pkg::IGDM_CODE_NONE;
      shut_ff <= 1'b0;
      warn_ff <= 1'b0;
      run_ff  <= 1'b0;
    end else if (CE) begin
      rxbd_ff <= nxt_rxbd;
      mand_ff <= nxt_mand;
      rxbw_ff <= nxt_rxbw;
      manw_ff <= nxt_manw;
      arm_ff  <= nxt_arm;
      bad_ff  <= nxt_bad;
      blk_ff  <= nxt_blk;
      code_ff <= nxt_code;
      shut_ff <= nxt_shut;
      warn_ff <= nxt_warn;
      run_ff  <= nxt_run;
    end
  end

  // ****************************************
  // Range programming
  // ****************************************
  always_comb begin
    nxt_prg   = prg_ff;
    nxt_live  = 32'h0;
    nxt_lo    = lo_ff;
    nxt_hi    = hi_ff;
    nxt_lo_en = lo_en_ff;
    nxt_hi_en = hi_en_ff;
    nxt_lvl   = lvl_ff;
    unique case (prg_ff)
      igdm_pkg::IGDM_PRG_IDLE: begin
        if (PRG_START && !run_ff) begin
          nxt_prg = igdm_pkg::IGDM_PRG_SHOW;
        end
      end
      igdm_pkg::IGDM_PRG_SHOW: begin
        if (PRG_DONE) begin
          nxt_prg = igdm_pkg::IGDM_PRG_LIVE;
        end
      end
      igdm_pkg::IGDM_PRG_LIVE: begin
        nxt_live = live_ff + 32'h1;
        if (live_ff >= LIVE_CYC - 1) begin
          nxt_prg = igdm_pkg::IGDM_PRG_EDIT;
        end
      end
      igdm_pkg::IGDM_PRG_EDIT: begin
        if (PRG_WRITE) begin
          nxt_lo    = NEW_LO;
          nxt_hi    = NEW_HI;
          nxt_lo_en = NEW_LO_EN;
          nxt_hi_en = NEW_HI_EN;
          nxt_lvl   = (NEW_LEVEL == 2'h0) ? lvl_ff : NEW_LEVEL;
          nxt_prg   = igdm_pkg::IGDM_PRG_CONFIRM;
        end
      end
      igdm_pkg::IGDM_PRG_CONFIRM: begin
        if (PRG_DONE) begin
          nxt_prg = igdm_pkg::IGDM_PRG_IDLE;
        end
      end
      default: nxt_prg = igdm_pkg::IGDM_PRG_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      prg_ff   <= igdm_pkg::IGDM_PRG_IDLE;
      live_ff  <= 32'h0;
      lo_ff    <= 8'h0;
      hi_ff    <= 8'hFF;
      lo_en_ff <= 1'b0;
      hi_en_ff <= 1'b0;
      lvl_ff   <= igdm_pkg::LEVEL_RESET;
    end else if (CE) begin
      prg_ff   <= nxt_prg;
      live_ff  <= nxt_live;
      lo_ff    <= nxt_lo;
      hi_ff    <= nxt_hi;
      lo_en_ff <= nxt_lo_en;
      hi_en_ff <= nxt_hi_en;
      lvl_ff   <= nxt_lvl;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign IGN_ENABLE             = run_ff && !shut_ff;
  assign SHUTDOWN               = shut_ff;
  assign MISFIRE                = run_ff && warn_ff && SPEED_HALF_MAX;
  assign RESTART_BLOCK          = (blk_ff != 32'h0);
  assign PRG_PHASE              = prg_ff;
  assign LOSS_SENSITIVITY_LEVEL = lvl_ff;

  // Display: code, stored limit or live value
  always_comb begin
    DISPLAY            = '0;
    DISPLAY.show_code  = (code_ff != igdm_pkg::IGDM_CODE_NONE);
    DISPLAY.code       = code_ff;
    DISPLAY.show_value = (prg_ff == igdm_pkg::IGDM_PRG_LIVE) || (prg_ff == igdm_pkg::IGDM_PRG_SHOW);
    DISPLAY.value      = (prg_ff == igdm_pkg::IGDM_PRG_LIVE) ? SENSE.rx_value : lo_ff;
    DISPLAY.confirm    = (prg_ff == igdm_pkg::IGDM_PRG_CONFIRM);
  end

  // ****************************************
  // Assertions
  // ****************************************
  rxb_dead_a: assert property (@(posedge CLK) disable iff (RST)
    CE && run_ff && !start_ok && rxbd_ff >= RXB_DEAD_CYC |=> shut_ff)
    else $error("receiver battery dead not shut down");
  main_dead_a: assert property (@(posedge CLK) disable iff (RST)
    CE && run_ff && !start_ok && mand_ff >= MAIN_DEAD_CYC |=> shut_ff)
    else $error("main battery dead not shut down");
  warn_fire_a: assert property (@(posedge CLK) disable iff (RST)
    MISFIRE |-> code_ff == igdm_pkg::IGDM_CODE_RXB_WARN || code_ff == igdm_pkg::IGDM_CODE_MAIN_WARN)
    else $error("misfire without warning code");
  warn_rxb_a: assert property (@(posedge CLK) disable iff (RST)
    CE && run_ff && !start_ok && !warn_ff && rxbw_ff >= WARN_CYC && rxbd_ff < RXB_DEAD_CYC &&
    mand_ff < MAIN_DEAD_CYC && bad_ff < glitch_len(lvl_ff) |=> code_ff == igdm_pkg::IGDM_CODE_RXB_WARN)
    else $error("receiver warning code missing");
  warn_main_a: assert property (@(posedge CLK) disable iff (RST)
    CE && run_ff && !start_ok && !warn_ff && rxbw_ff < WARN_CYC && manw_ff >= WARN_CYC &&
    rxbd_ff < RXB_DEAD_CYC && mand_ff < MAIN_DEAD_CYC && bad_ff < glitch_len(lvl_ff)
    |=> code_ff == igdm_pkg::IGDM_CODE_MAIN_WARN)
    else $error("main warning code missing");
  rx_loss_a: assert property (@(posedge CLK) disable iff (RST)
    CE && run_ff && !start_ok && bad_ff >= glitch_len(lvl_ff) |=> shut_ff)
    else $error("receiver loss not shut down");
  code_show_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(shut_ff) |-> DISPLAY.show_code)
    else $error("shutdown code not shown");
  restart_blk_a: assert property (@(posedge CLK) disable iff (RST)
    CE && $rose(shut_ff) |-> RESTART_BLOCK && !IGN_ENABLE)
    else $error("restart not blocked");
  start_clr_a: assert property (@(posedge CLK) disable iff (RST)
    CE && start_ok |=> code_ff == igdm_pkg::IGDM_CODE_NONE && !shut_ff)
    else $error("codes not cleared at restart");
  arm_hold_a: assert property (@(posedge CLK) disable iff (RST)
    !armed |-> bad_ff == 8'h0)
    else $error("receiver monitored before arming");
  live_next_a: assert property (@(posedge CLK) disable iff (RST)
    CE && prg_ff == igdm_pkg::IGDM_PRG_LIVE && live_ff >= LIVE_CYC - 1 |=> prg_ff == igdm_pkg::IGDM_PRG_EDIT)
    else $error("live window did not end");
  range_kill_a: assert property (@(posedge CLK) disable iff (RST)
    CE && run_ff && !start_ok && rxbd_ff < RXB_DEAD_CYC && mand_ff < MAIN_DEAD_CYC &&
    bad_ff >= glitch_len(lvl_ff) && SENSE.rx_present |=> code_ff == igdm_pkg::IGDM_CODE_RANGE_KILL)
    else $error("range kill code missing");
  ce_hold_a: assert property (@(posedge CLK) disable iff (RST)
    !CE |=> $stable(code_ff) && $stable(prg_ff) && $stable(blk_ff) && $stable(run_ff))
    else $error("state moved while clock enable low");

endmodule // igdm_monitor

// File: pkg/igdm_pkg.sv
package igdm_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned RXB_DEAD_SEC    = 2;
  localparam int unsigned MAIN_DEAD_SEC   = 5;
  localparam int unsigned WARN_SEC        = 5;
  localparam int unsigned RESTART_SEC     = 5;
  localparam int unsigned LIVE_SEC        = 10;
  localparam int unsigned ARM_SEC         = 7;
  localparam int unsigned RXB_DEAD_CYC    = RXB_DEAD_SEC * CLK_HZ;
  localparam int unsigned MAIN_DEAD_CYC   = MAIN_DEAD_SEC * CLK_HZ;
  localparam int unsigned WARN_CYC        = WARN_SEC * CLK_HZ;
  localparam int unsigned RESTART_CYC     = RESTART_SEC * CLK_HZ;
  localparam int unsigned LIVE_CYC        = LIVE_SEC * CLK_HZ;
  localparam int unsigned ARM_CYC         = ARM_SEC * CLK_HZ;

  // ****************************************
  // Glitch filter counts per level
  // ****************************************
  localparam logic [7:0] GLITCH_LVL1 = 8'h10;
  localparam logic [7:0] GLITCH_LVL2 = 8'h08;
  localparam logic [7:0] GLITCH_LVL3 = 8'h02;
  localparam logic [1:0] LEVEL_RESET = 2'h1;

  // ****************************************
  // Diagnostic codes
  // ****************************************
  typedef enum logic [2:0] {
    IGDM_CODE_NONE,
    IGDM_CODE_RX_MISSING,
    IGDM_CODE_RXB_DEAD,
    IGDM_CODE_MAIN_DEAD,
    IGDM_CODE_RXB_WARN,
    IGDM_CODE_MAIN_WARN,
    IGDM_CODE_RANGE_KILL
  } igdm_code_t;

  // Range programming phases
  typedef enum logic [2:0] {
    IGDM_PRG_IDLE,
    IGDM_PRG_SHOW,
    IGDM_PRG_LIVE,
    IGDM_PRG_EDIT,
    IGDM_PRG_CONFIRM
  } igdm_prg_t;

  // Sensor inputs travelling together
  typedef struct packed {
    logic       rx_present;
    logic       rx_sample;
    logic [7:0] rx_value;
    logic       rxb_below_dead;
    logic       rxb_below_warn;
    logic       main_below_dead;
    logic       main_below_warn;
  } igdm_sense_t;

  // Display content
  typedef struct packed {
    logic       show_code;
    igdm_code_t code;
    logic       show_value;
    logic [7:0] value;
    logic       confirm;
  } igdm_disp_t;

endpackage

// File: bench/igdm_rx_model.sv
`timescale 1ns/1ps
// ****************************************
// Receiver channel and battery sensing
// ****************************************
module igdm_rx_model (
  input  wire logic          clk,
  input  wire logic          present,
  input  wire logic [7:0]    value,
  input  wire logic [3:0]    low,
  output igdm_pkg::igdm_sense_t sense
);
  logic [1:0] div_ff = 2'h0;

  initial sense = '0;

  // One receiver frame every four cycles; lost channel shows a toggling value
  always @(posedge clk) begin
    div_ff                <= div_ff + 2'h1;
    sense.rx_sample       <= (div_ff == 2'h3);
    sense.rx_present      <= present;
    sense.rx_value        <= present ? value : ~sense.rx_value;
    sense.rxb_below_dead  <= low[3];
    sense.rxb_below_warn  <= low[2];
    sense.main_below_dead <= low[1];
    sense.main_below_warn <= low[0];
  end
endmodule // igdm_rx_model

// File: bench/igdm_monitor_test.sv
`timescale 1ns/1ps
module ignition_diag_monitor_test;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int RXB_C = 20;
  localparam int MAIN_C = 30;
  localparam int WARN_C = 25;
  localparam int RST_C = 20;
  localparam int LIVE_C = 20;
  logic                  CLK = 1'b0;
  logic                  RST = 1'b1;
  logic                  start_s = 1'b0;
  logic                  half_s = 1'b0;
  logic                  p_start = 1'b0;
  logic                  p_write = 1'b0;
  logic                  p_done = 1'b0;
  logic                  ce_s = 1'b1;
  logic [1:0]            lvl_s = 2'h3;
  logic                  present = 1'b1;
  logic [7:0]            value = 8'h30;
  logic [3:0]            low = 4'h0;
  logic                  ign, shut, misfire, blk;
  logic [1:0]            lvl;
  igdm_pkg::igdm_sense_t sense;
  igdm_pkg::igdm_prg_t   phase;
  igdm_pkg::igdm_disp_t  disp;
  int                    failures = 0;
  int                    checked = 0;

  always #20 CLK = ~CLK;

  igdm_rx_model i_rx (.clk(CLK), .present(present), .value(value), .low(low), .sense(sense));

  igdm_monitor #(.RXB_DEAD_CYC(RXB_C), .MAIN_DEAD_CYC(MAIN_C), .WARN_CYC(WARN_C), .RESTART_CYC(RST_C),
    .LIVE_CYC(LIVE_C), .ARM_CYC(40)) i_dut (
    .CLK(CLK), .RST(RST), .CE(ce_s), .SENSE(sense), .ENGINE_START(start_s), .SPEED_HALF_MAX(half_s),
    .PRG_START(p_start), .PRG_WRITE(p_write), .PRG_DONE(p_done), .NEW_LO_EN(1'b1), .NEW_LO(8'h19),
    .NEW_HI_EN(1'b1), .NEW_HI(8'h4E), .NEW_LEVEL(lvl_s), .IGN_ENABLE(ign), .SHUTDOWN(shut),
    .MISFIRE(misfire), .RESTART_BLOCK(blk), .PRG_PHASE(phase), .DISPLAY(disp), .LOSS_SENSITIVITY_LEVEL(lvl));

  // ****************************************
  // Compare and drive tasks
  // ****************************************
  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t flag mismatch", $time);
    end
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t value mismatch", $time);
    end
  endtask

  task automatic cmp_code(input igdm_pkg::igdm_code_t got, input igdm_pkg::igdm_code_t exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t code mismatch", $time);
    end
  endtask

  task automatic cmp_prg(input igdm_pkg::igdm_prg_t got, input igdm_pkg::igdm_prg_t exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t phase mismatch", $time);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge CLK);
  endtask

  task automatic start_eng();
    start_s = 1'b1;
    tick(1);
    start_s = 1'b0;
    tick(1);
  endtask

  task automatic end_of_test();
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One sensed condition held past its qualifying time, then cleared by a start
  task automatic fault(input int b, input int cyc, input igdm_pkg::igdm_code_t code, input logic kill);
    low[b] = 1'b1;
    tick(cyc - 3);
    cmp_code(disp.code, igdm_pkg::IGDM_CODE_NONE);
    tick(6);
    cmp_code(disp.code, code);
    cmp_bit(disp.show_code, 1'b1);
    cmp_bit(shut, kill);
    cmp_bit(ign, !kill);
    low[b] = 1'b0;
    if (kill) begin
      cmp_bit(blk, 1'b1);
      start_eng();
      cmp_bit(ign, 1'b0);
      tick(RST_C - 8);
      cmp_bit(blk, 1'b1);
      tick(8);
      cmp_bit(blk, 1'b0);
    end else begin
      cmp_bit(misfire, 1'b0);
      half_s = 1'b1;
      tick(1);
      cmp_bit(misfire, 1'b1);
      half_s = 1'b0;
    end
    start_eng();
    cmp_code(disp.code, igdm_pkg::IGDM_CODE_NONE);
    cmp_bit(ign, 1'b1);
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    tick(4);
    RST = 1'b0;
    cmp_byte({6'h00, lvl}, 8'h01);
    cmp_bit(ign, 1'b0);
    start_eng();
    cmp_bit(ign, 1'b1);
    fault(3, RXB_C, igdm_pkg::IGDM_CODE_RXB_DEAD, 1'b1);
    fault(1, MAIN_C, igdm_pkg::IGDM_CODE_MAIN_DEAD, 1'b1);
    fault(2, WARN_C, igdm_pkg::IGDM_CODE_RXB_WARN, 1'b0);
    fault(0, WARN_C, igdm_pkg::IGDM_CODE_MAIN_WARN, 1'b0);
    present = 1'b0;
    tick(30);
    cmp_bit(shut, 1'b0);
    tick(90);
    cmp_bit(shut, 1'b1);
    cmp_code(disp.code, igdm_pkg::IGDM_CODE_RX_MISSING);
    present = 1'b1;
    p_start = 1'b1;
    tick(1);
    p_start = 1'b0;
    tick(1);
    cmp_prg(phase, igdm_pkg::IGDM_PRG_SHOW);
    cmp_byte(disp.value, 8'h00);
    cmp_bit(disp.show_value, 1'b1);
    p_done = 1'b1;
    tick(1);
    p_done = 1'b0;
    tick(4);
    cmp_prg(phase, igdm_pkg::IGDM_PRG_LIVE);
    cmp_byte(disp.value, 8'h30);
    ce_s = 1'b0;
    tick(30);
    cmp_prg(phase, igdm_pkg::IGDM_PRG_LIVE);
    ce_s = 1'b1;
    tick(LIVE_C);
    cmp_prg(phase, igdm_pkg::IGDM_PRG_EDIT);
    p_write = 1'b1;
    tick(1);
    p_write = 1'b0;
    tick(1);
    cmp_prg(phase, igdm_pkg::IGDM_PRG_CONFIRM);
    cmp_bit(disp.confirm, 1'b1);
    p_done = 1'b1;
    tick(1);
    p_done = 1'b0;
    tick(1);
    cmp_prg(phase, igdm_pkg::IGDM_PRG_IDLE);
    cmp_byte({6'h00, lvl}, 8'h03);
    tick(RST_C);
    start_eng();
    tick(20);
    cmp_bit(shut, 1'b0);
    value = 8'h14;
    tick(20);
    cmp_bit(shut, 1'b1);
    cmp_code(disp.code, igdm_pkg::IGDM_CODE_RANGE_KILL);
    end_of_test();
  end

  // Watchdog against a hang
  initial begin
    tick(5000);
    failures++;
    end_of_test();
  end
endmodule // ignition_diag_monitor_test
